// ---- rtl/link_block_pkg.sv ----
/*
 * constants for the link control block: frame type codes, status code bit
 * positions, field widths and reset values.
 * assumes nothing of its surroundings.
 */
package link_block_pkg;
  localparam int STATION_W = 16;
  localparam int LEN_W = 16;
  localparam int CODE_W = 16;
  localparam int ADDR_BYTES = 6;
  // frame type codes
  localparam logic [7:0] FT_MAC = 8'h02;
  localparam logic [7:0] FT_INFO = 8'h04;
  localparam logic [7:0] FT_UNNUM = 8'h06;
  localparam logic [7:0] FT_XID_CMD_P1 = 8'h08;
  localparam logic [7:0] FT_XID_CMD_P0 = 8'h0a;
  localparam logic [7:0] FT_XID_RSP_F1 = 8'h0c;
  localparam logic [7:0] FT_XID_RSP_F0 = 8'h0e;
  localparam logic [7:0] FT_TEST_RSP_F1 = 8'h10;
  localparam logic [7:0] FT_TEST_RSP_F0 = 8'h12;
  localparam logic [7:0] FT_OTHER = 8'h14;
  localparam logic [7:0] FT_BRIDGE = 8'h20;
  // status code bit positions
  localparam int SB_LOST = 0;
  localparam int SB_DISC = 1;
  localparam int SB_REJ_RCVD = 2;
  localparam int SB_REJ_SENT = 3;
  localparam int SB_BAL_REQ = 4;
  localparam int SB_NEW_OPEN = 5;
  localparam int SB_PEER_BUSY = 6;
  localparam int SB_PEER_UNBUSY = 7;
  localparam int SB_INACT = 8;
  localparam int SB_SATURATE = 9;
  localparam int SB_PRIORITY = 10;
  localparam int SB_LOCAL_BUSY = 15;
  localparam logic [15:0] STATUS_RSVD_MASK = 16'h7800;
  localparam logic [7:0] CTR_BEFORE_SAT = 8'hfe;
  localparam logic [7:0] CTR_SAT = 8'hff;
  localparam logic [15:0] RESET_ZERO16 = 16'h0000;
  // receive kind selector, decoded into the frame type code
  typedef enum logic [3:0] {
    RK_MAC, RK_INFO, RK_UNNUM, RK_XID_CMD, RK_XID_RSP, RK_TEST_RSP, RK_OTHER
  } rx_kind_t;
endpackage

// ---- rtl/link_counter_watch.sv ----
/*
 * watches a set of 8-bit link error counters and pulses when any of them
 * steps from 254 to 255.
 * assumes counter values are synchronous to ref_clk.
 */
`timescale 1ns/100ps
module link_counter_watch
  import link_block_pkg::*;
#(
  parameter int NUM_CTR = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [8*NUM_CTR-1:0] ctr_values,
  output logic saturate_pulse
);
  logic [8*NUM_CTR-1:0] prev_q;
  logic [8*NUM_CTR-1:0] prev_d;
  logic [NUM_CTR-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < NUM_CTR; g++) begin : g_ctr
      assign hit[g] = (prev_q[8*g +: 8] == CTR_BEFORE_SAT) &&
                      (ctr_values[8*g +: 8] == CTR_SAT); // R16
    end
  endgenerate

  always_comb begin
    prev_d = ctr_values;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign saturate_pulse = |hit;
endmodule

// ---- rtl/link_control_block.sv ----
/*
 * link control block: receive routing fields and link status fields that
 * the host reads by direct access, plus the two interrupts that follow
 * each update.
 * assumes event strobes are one-cycle pulses synchronous to ref_clk and
 * that the host samples the fields only after an interrupt pulse.
 */
// Summary of operation
// R1: block updates only while link layer support is enabled
// R2: fields are complete no later than the matching interrupt pulse
// R3: host reads these fields directly; nothing is pushed to host memory
// R4: receive event stores destination station and MAC header length
// R5: receive event stores link header length
// R6: frame length excludes checksum; host adds four when passing checksum
// R7: receive event stores frame type code from the kind table
// R8: frames not for this station report type 20
// R9: status event stores station and 16-bit code; bit 0 is link lost
// R10: bit 1 on disconnect received or own disconnect acknowledged
// R11: bit 2 on frame reject received
// R12: bit 3 after frame reject sent
// R13: bit 4 on mode request for open station, bit 5 on new open
// R14: bit 6 peer enters busy, bit 7 peer leaves busy
// R15: bit 8 on inactivity expiry, only for disconnected links
// R16: bit 9 when an error counter steps from 254 to 255
// R17: bit 10 on first transmit attempt after priority lowered
// R18: bits 11 to 14 always zero
// R19: bit 15 on local busy unless caused by host flow control
// R20: status event records the frame reject response field
// R21: status event records the new access priority
// R22: status event records peer 6-byte address and peer service point
// R23: receive interrupt needs only a frame ready in internal buffers
`timescale 1ns/100ps
module link_control_block
  import link_block_pkg::*;
#(
  parameter int NUM_CTR = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic link_layer_enable,
  // receive side
  input wire logic rx_frame_ready,
  input wire logic [STATION_W-1:0] rx_station,
  input wire logic [LEN_W-1:0] rx_mac_hdr_len,
  input wire logic [LEN_W-1:0] rx_link_hdr_len,
  input wire logic [LEN_W-1:0] rx_total_len,
  input wire rx_kind_t rx_kind,
  input wire logic rx_cmd_not_rsp,
  input wire logic rx_poll_final,
  input wire logic rx_not_addressed,
  // link status events
  input wire logic ev_valid,
  input wire logic [STATION_W-1:0] ev_station,
  input wire logic ev_link_lost,
  input wire logic ev_disc_rcvd,
  input wire logic ev_disc_acked,
  input wire logic ev_reject_rcvd,
  input wire logic ev_reject_sent,
  input wire logic ev_mode_req,
  input wire logic ev_station_open,
  input wire logic ev_peer_busy,
  input wire logic ev_peer_unbusy,
  input wire logic ev_inact_expired,
  input wire logic ev_link_disconnected,
  input wire logic ev_priority_lowered,
  input wire logic ev_user_tx_attempt,
  input wire logic ev_local_busy,
  input wire logic ev_busy_by_flow_ctl,
  input wire logic [8*NUM_CTR-1:0] error_counters,
  input wire logic [23:0] ev_reject_field,
  input wire logic [7:0] ev_priority,
  input wire logic [8*ADDR_BYTES-1:0] ev_peer_addr,
  input wire logic [7:0] ev_peer_sap,
  // block contents as read by the host
  output logic [STATION_W-1:0] receive_station_ident,
  output logic [LEN_W-1:0] mac_header_length,
  output logic [LEN_W-1:0] link_header_length,
  output logic [LEN_W-1:0] received_frame_length,
  output logic [7:0] frame_type,
  output logic [STATION_W-1:0] status_station_ident,
  output logic [CODE_W-1:0] link_status_code,
  output logic [23:0] reject_response_field,
  output logic [7:0] new_priority_field,
  output logic [8*ADDR_BYTES-1:0] peer_address,
  output logic [7:0] peer_service_point,
  output logic receive_pending_irq,
  output logic link_change_interrupt
);
  logic rst_s1_q;
  logic rst_n;
  logic saturate_pulse;

  // two-stage reset release: assertion clears everything at once, while
  // release is synchronous so no flop sees reset end near a clock edge
  // and settles differently from its neighbours
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // counter history starts at zero, so a counter already at 255 when
  // reset ends is never reported
  link_counter_watch #(.NUM_CTR(NUM_CTR)) u_watch (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctr_values(error_counters),
    .saturate_pulse(saturate_pulse)
  );

  // receive side fields
  logic [STATION_W-1:0] rx_station_q, rx_station_d;
  logic [LEN_W-1:0] mac_len_q, mac_len_d;
  logic [LEN_W-1:0] link_len_q, link_len_d;
  logic [LEN_W-1:0] total_len_q, total_len_d;
  logic [7:0] ftype_q, ftype_d;
  logic rx_irq_q, rx_irq_d;
  logic [7:0] ftype_code;

  // illegal kind codes fall back to the other-frame code rather than
  // leaving a code the host cannot decode
  always_comb begin
    // a frame not for this station reports bridge data whatever its kind
    if (rx_not_addressed) begin
      ftype_code = FT_BRIDGE; // R8
    end else begin
      unique case (rx_kind) // R7
        RK_MAC: ftype_code = FT_MAC;
        RK_INFO: ftype_code = FT_INFO;
        RK_UNNUM: ftype_code = FT_UNNUM;
        RK_XID_CMD: ftype_code = rx_poll_final ? FT_XID_CMD_P1 : FT_XID_CMD_P0;
        RK_XID_RSP: ftype_code = rx_poll_final ? FT_XID_RSP_F1 : FT_XID_RSP_F0;
        RK_TEST_RSP:
          ftype_code = rx_poll_final ? FT_TEST_RSP_F1 : FT_TEST_RSP_F0;
        default: ftype_code = FT_OTHER;
      endcase
    end
  end

  always_comb begin
    rx_station_d = rx_station_q;
    mac_len_d = mac_len_q;
    link_len_d = link_len_q;
    total_len_d = total_len_q;
    ftype_d = ftype_q;
    rx_irq_d = 1'b0;
    // a refused frame leaves the fields alone, so the host still reads
    // the last accepted one
    if (link_layer_enable && rx_frame_ready) begin // R1 R23
      rx_station_d = rx_station; // R4
      mac_len_d = rx_mac_hdr_len; // R4
      link_len_d = rx_link_hdr_len; // R5
      total_len_d = rx_total_len; // R6
      ftype_d = ftype_code;
      rx_irq_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_station_q <= RESET_ZERO16;
      mac_len_q <= RESET_ZERO16;
      link_len_q <= RESET_ZERO16;
      total_len_q <= RESET_ZERO16;
      ftype_q <= 8'h00;
      rx_irq_q <= 1'b0;
    end else begin
      rx_station_q <= rx_station_d;
      mac_len_q <= mac_len_d;
      link_len_q <= link_len_d;
      total_len_q <= total_len_d;
      ftype_q <= ftype_d;
      rx_irq_q <= rx_irq_d;
    end
  end

  // priority reduction waits for the first user transmit attempt
  logic prio_pend_q, prio_pend_d;
  logic prio_fire;
  assign prio_fire = (prio_pend_q || ev_priority_lowered) &&
                     ev_user_tx_attempt; // R17

  always_comb begin
    prio_pend_d = prio_pend_q;
    if (ev_priority_lowered) begin
      prio_pend_d = 1'b1;
    end else if (prio_fire) begin
      prio_pend_d = 1'b0;
    end
    // lowering and attempt in one cycle report at once, nothing stays armed
    if (ev_priority_lowered && ev_user_tx_attempt) begin
      prio_pend_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_pend_q <= 1'b0;
    end else begin
      prio_pend_q <= prio_pend_d;
    end
  end

  // status code assembly
  // plain flags count only with ev_valid, so a flag left high between
  // events cannot leak into a counter or priority report
  logic [CODE_W-1:0] flag_code;
  logic [CODE_W-1:0] code_now;
  always_comb begin
    flag_code = '0;
    flag_code[SB_LOST] = ev_link_lost; // R9
    flag_code[SB_DISC] = ev_disc_rcvd | ev_disc_acked; // R10
    flag_code[SB_REJ_RCVD] = ev_reject_rcvd; // R11
    flag_code[SB_REJ_SENT] = ev_reject_sent; // R12
    // a mode request reports one of two outcomes, never both
    flag_code[SB_BAL_REQ] = ev_mode_req & ~ev_station_open; // R13
    flag_code[SB_NEW_OPEN] = ev_mode_req & ev_station_open; // R13
    flag_code[SB_PEER_BUSY] = ev_peer_busy; // R14
    flag_code[SB_PEER_UNBUSY] = ev_peer_unbusy; // R14
    flag_code[SB_INACT] = ev_inact_expired & ev_link_disconnected; // R15
    flag_code[SB_LOCAL_BUSY] = ev_local_busy & ~ev_busy_by_flow_ctl; // R19
    code_now = ev_valid ? flag_code : '0;
    code_now[SB_SATURATE] = saturate_pulse; // R16
    code_now[SB_PRIORITY] = prio_fire; // R17
    code_now = code_now & ~STATUS_RSVD_MASK; // R18
  end

  // link status fields
  logic [STATION_W-1:0] st_station_q, st_station_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic [23:0] rej_q, rej_d;
  logic [7:0] prio_q, prio_d;
  logic [8*ADDR_BYTES-1:0] paddr_q, paddr_d;
  logic [7:0] psap_q, psap_d;
  logic st_irq_q, st_irq_d;
  logic st_event;
  logic st_trigger;

  // a trigger only counts when some code bit would be set
  assign st_trigger = ev_valid || saturate_pulse || prio_fire;
  assign st_event = link_layer_enable && st_trigger &&
                    (code_now != '0); // R1

  always_comb begin
    st_station_d = st_station_q;
    code_d = code_q;
    rej_d = rej_q;
    prio_d = prio_q;
    paddr_d = paddr_q;
    psap_d = psap_q;
    st_irq_d = 1'b0;
    if (st_event) begin
      st_station_d = ev_station; // R9
      code_d = code_now; // R9
      // station, priority and peer fields follow every accepted event;
      // the reject field keeps its last value when no reject is involved
      if (ev_reject_rcvd || ev_reject_sent) begin
        rej_d = ev_reject_field; // R20
      end
      prio_d = ev_priority; // R21
      paddr_d = ev_peer_addr; // R22
      psap_d = ev_peer_sap; // R22
      st_irq_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_station_q <= RESET_ZERO16;
      code_q <= RESET_ZERO16;
      rej_q <= 24'h000000;
      prio_q <= 8'h00;
      paddr_q <= '0;
      psap_q <= 8'h00;
      st_irq_q <= 1'b0;
    end else begin
      st_station_q <= st_station_d;
      code_q <= code_d;
      rej_q <= rej_d;
      prio_q <= prio_d;
      paddr_q <= paddr_d;
      psap_q <= psap_d;
      st_irq_q <= st_irq_d;
    end
  end

  // fields and pulse land on one edge, so a host that waits for the pulse
  // never reads a half-written block
  assign receive_station_ident = rx_station_q;
  assign mac_header_length = mac_len_q;
  assign link_header_length = link_len_q;
  assign received_frame_length = total_len_q;
  assign frame_type = ftype_q;
  assign status_station_ident = st_station_q;
  assign link_status_code = code_q;
  assign reject_response_field = rej_q;
  assign new_priority_field = prio_q;
  assign peer_address = paddr_q;
  assign peer_service_point = psap_q;

  // interrupt pulses, one cycle each
  assign receive_pending_irq = rx_irq_q; // R2
  assign link_change_interrupt = st_irq_q; // R2
endmodule

// ---- verif/lcb_sva.sv ----
/* assertions on the link control block ports.
   bound into every link_control_block instance at the foot. */
`timescale 1ns/100ps
module lcb_sva
  import link_block_pkg::*;
#(
  parameter int NUM_CTR = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic link_layer_enable,
  input wire logic rx_frame_ready,
  input wire logic [STATION_W-1:0] rx_station,
  input wire logic [LEN_W-1:0] rx_link_hdr_len,
  input wire logic [LEN_W-1:0] rx_total_len,
  input wire logic rx_not_addressed,
  input wire logic ev_valid,
  input wire logic ev_link_lost,
  input wire logic ev_inact_expired,
  input wire logic ev_link_disconnected,
  input wire logic ev_local_busy,
  input wire logic ev_busy_by_flow_ctl,
  input wire logic [STATION_W-1:0] receive_station_ident,
  input wire logic [LEN_W-1:0] link_header_length,
  input wire logic [LEN_W-1:0] received_frame_length,
  input wire logic [7:0] frame_type,
  input wire logic [CODE_W-1:0] link_status_code,
  input wire logic receive_pending_irq,
  input wire logic link_change_interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rx;
    rx_frame_ready && link_layer_enable;
  endsequence
  sequence s_ev;
    ev_valid && link_layer_enable;
  endsequence
  property p_rx_irq;
    s_rx |=> receive_pending_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
  property p_rx_cause;
    receive_pending_irq |-> $past(rx_frame_ready && link_layer_enable);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("stray rx irq");
  property p_off;
    !link_layer_enable |=> !receive_pending_irq && !link_change_interrupt;
  endproperty
  a_off: assert property (p_off) else $error("irq while disabled");
  property p_rx_dst;
    s_rx |=> receive_station_ident == $past(rx_station);
  endproperty
  a_rx_dst: assert property (p_rx_dst) else $error("bad station");
  property p_rx_len;
    s_rx |=> link_header_length == $past(rx_link_hdr_len)
      && received_frame_length == $past(rx_total_len);
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("bad length");
  property p_bridge;
    s_rx ##0 rx_not_addressed |=> frame_type == 8'h20;
  endproperty
  a_bridge: assert property (p_bridge) else $error("bad bridge type");
  property p_rsvd;
    (link_status_code & 16'h7800) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_lost;
    s_ev ##0 ev_link_lost |=> link_change_interrupt && link_status_code[0];
  endproperty
  a_lost: assert property (p_lost) else $error("lost link missed");
  property p_inact;
    link_change_interrupt && link_status_code[8]
      |-> $past(ev_inact_expired && ev_link_disconnected);
  endproperty
  a_inact: assert property (p_inact) else $error("bad inactivity");
  property p_local;
    link_change_interrupt && link_status_code[15]
      |-> $past(ev_local_busy && !ev_busy_by_flow_ctl);
  endproperty
  a_local: assert property (p_local) else $error("bad local busy");
endmodule

bind link_control_block lcb_sva #(.NUM_CTR(NUM_CTR)) i_lcb_sva (
  .ref_clk, .rst_b, .link_layer_enable, .rx_frame_ready, .rx_station,
  .rx_link_hdr_len, .rx_total_len, .rx_not_addressed, .ev_valid,
  .ev_link_lost, .ev_inact_expired, .ev_link_disconnected, .ev_local_busy,
  .ev_busy_by_flow_ctl, .receive_station_ident, .link_header_length,
  .received_frame_length, .frame_type, .link_status_code,
  .receive_pending_irq, .link_change_interrupt);

// ---- verif/host_reader.sv ----
/* host side model: reads the block fields after each interrupt.
   assumes packed field groups and one-cycle irq pulses. */
`timescale 1ns/100ps
module host_reader (
  input wire logic ref_clk,
  input wire logic rx_irq,
  input wire logic st_irq,
  input wire logic [71:0] rx_f,
  input wire logic [119:0] st_f,
  output logic rx_seen,
  output logic st_seen,
  output logic [71:0] rx_c,
  output logic [119:0] st_c
);
  // read only once the pulse says the fields are complete
  always @(posedge ref_clk) begin
    rx_seen <= rx_irq;
    st_seen <= st_irq;
    if (rx_irq) rx_c <= {rx_f[71:24], rx_f[23:8] + 16'h0004, rx_f[7:0]};
    if (st_irq) st_c <= st_f;
  end
endmodule

// ---- verif/link_control_block_bench.sv ----
/* self-checking bench for link_control_block with a host model.
   assumes the checker binds itself; all inputs change at negedge. */
`timescale 1ns/100ps
module link_control_block_bench;
  import link_block_pkg::*;
  logic ref_clk, rst_b, en, rdy, na, pf, ev;
  logic [15:0] sta, mh, lh, tl, es;
  logic [14:0] fl;
  logic [31:0] ctr;
  logic [23:0] rej, xrej;
  logic [7:0] pri, sap;
  logic [47:0] adr;
  rx_kind_t kind;
  wire logic [15:0] o_sta, o_mh, o_lh, o_tl, o_ss, o_code;
  wire logic [7:0] o_ft, o_pri, o_sap;
  wire logic [23:0] o_rej;
  wire logic [47:0] o_adr;
  wire logic rx_irq, st_irq, rx_seen, st_seen;
  wire logic [71:0] rx_c;
  wire logic [119:0] st_c;
  logic [71:0] rq[$];
  logic [119:0] sq[$], mq[$];
  logic [7:0] ft_tab[7] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [14:0] tf[17] = '{15'h0001, 15'h0002, 15'h0004, 15'h0008, 15'h0010,
    15'h0020, 15'h0060, 15'h0080, 15'h0100, 15'h0600, 15'h0200, 15'h2000,
    15'h6000, 15'h0800, 15'h1000, 15'h1000, 15'h0011};
  logic [15:0] tc[17] = '{16'h0001, 16'h0002, 16'h0002, 16'h0004, 16'h0008,
    16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0000, 16'h8000,
    16'h0000, 16'h0000, 16'h0400, 16'h0000, 16'h0009};
  int fails, checks, seed;

  link_control_block i_link_control_block (.ref_clk(ref_clk), .rst_b(rst_b),
    .link_layer_enable(en), .rx_frame_ready(rdy), .rx_station(sta),
    .rx_mac_hdr_len(mh), .rx_link_hdr_len(lh), .rx_total_len(tl),
    .rx_kind(kind), .rx_cmd_not_rsp(pf), .rx_poll_final(pf),
    .rx_not_addressed(na), .ev_valid(ev), .ev_station(es),
    .ev_link_lost(fl[0]), .ev_disc_rcvd(fl[1]), .ev_disc_acked(fl[2]),
    .ev_reject_rcvd(fl[3]), .ev_reject_sent(fl[4]), .ev_mode_req(fl[5]),
    .ev_station_open(fl[6]), .ev_peer_busy(fl[7]), .ev_peer_unbusy(fl[8]),
    .ev_inact_expired(fl[9]), .ev_link_disconnected(fl[10]),
    .ev_priority_lowered(fl[11]), .ev_user_tx_attempt(fl[12]),
    .ev_local_busy(fl[13]), .ev_busy_by_flow_ctl(fl[14]),
    .error_counters(ctr), .ev_reject_field(rej), .ev_priority(pri),
    .ev_peer_addr(adr), .ev_peer_sap(sap), .receive_station_ident(o_sta),
    .mac_header_length(o_mh), .link_header_length(o_lh),
    .received_frame_length(o_tl), .frame_type(o_ft),
    .status_station_ident(o_ss), .link_status_code(o_code),
    .reject_response_field(o_rej), .new_priority_field(o_pri),
    .peer_address(o_adr), .peer_service_point(o_sap),
    .receive_pending_irq(rx_irq), .link_change_interrupt(st_irq));
  host_reader i_host_reader (.ref_clk(ref_clk), .rx_irq(rx_irq),
    .st_irq(st_irq), .rx_f({o_sta, o_mh, o_lh, o_tl, o_ft}),
    .st_f({o_ss, o_code, o_rej, o_pri, o_adr, o_sap}), .rx_seen(rx_seen),
    .st_seen(st_seen), .rx_c(rx_c), .st_c(st_c));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp_rx(logic [71:0] e, logic [71:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED receive fields exp %h got %h", e, s);
    end
  endtask

  task automatic cmp_st(logic [119:0] e, logic [119:0] m, logic [119:0] s);
    checks++;
    if ((s & m) !== (e & m)) begin
      fails++;
      $display("CHECK FAILED status fields exp %h got %h", e & m, s & m);
    end
  endtask

  // an unexpected pulse finds an empty queue and compares against unknown
  always @(negedge ref_clk) begin
    if (rx_seen) cmp_rx(rq.size() ? rq.pop_front() : 'x, rx_c);
    if (st_seen) cmp_st(sq.size() ? sq.pop_front() : 'x,
      mq.size() ? mq.pop_front() : '1, st_c);
  end

  task automatic rx(int k, logic p, logic n);
    @(negedge ref_clk);
    {rdy, pf, na} = {1'b1, p, n};
    kind = rx_kind_t'(k);
    {sta, mh, lh, tl} = {$random(seed), $random(seed)};
    if (en) rq.push_back({sta, mh, lh, tl + 16'h0004, n ? 8'h20 :
      k > 6 ? 8'h14 :
      ft_tab[k] + ((k > 2 && k < 6 && !p) ? 8'h02 : 8'h00)});
  endtask

  task automatic st(logic [14:0] f, logic [15:0] c);
    @(negedge ref_clk);
    {ev, fl, es, pri, sap} = {1'b1, f, $random(seed)};
    {rej, adr} = 72'({$random(seed), $random(seed), $random(seed)});
    if (en && c != 16'h0000) begin
      if (f[3] || f[4]) xrej = rej;
      sq.push_back({es, c, xrej, pri, adr, sap});
      mq.push_back('1);
    end
  endtask

  task automatic idle(int n);
    @(negedge ref_clk);
    {rdy, ev, fl} = '0;
    repeat (n) @(negedge ref_clk);
  endtask

  initial begin
    {rst_b, rdy, na, pf, ev, fl, ctr, xrej} = '0;
    {sta, mh, lh, tl, es, rej, pri, sap, adr} = '0;
    {en, seed, fails, checks} = {1'b1, 32'hcdbc, 64'h0};
    kind = RK_MAC;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) rst_b = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (int k = 0; k < 7; k++) for (int p = 0; p < 2; p++) rx(k, p[0], 0);
    rx(1, 1'b0, 1'b1);
    rx(9, 1'b0, 1'b0);
    idle(1);
    en = 1'b0;
    rx(2, 1'b0, 1'b0);
    st(15'h0001, 16'h0001);
    idle(1);
    en = 1'b1;
    for (int i = 0; i < 17; i++) st(tf[i], tc[i]);
    idle(2);
    ctr[23:16] = 8'hfe;
    @(negedge ref_clk) ctr[23:16] = 8'hff;
    sq.push_back({16'h0, 16'h0200, 88'h0});
    mq.push_back({16'h0, 16'hffff, 88'h0});
    idle(6);
    if (rq.size() || sq.size()) fails++;
    results();
  end

  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    results();
  end
endmodule
